/* hdl/stc_map.svh */
// register map, field positions, reset values and timing counts of the timer block
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define STC_IDX_C0_HIGH   8'h0c
`define STC_IDX_C0_LOW    8'h0d
`define STC_IDX_C0_CTRL   8'h0e
`define STC_IDX_C1_HIGH   8'h0f
`define STC_IDX_C1_LOW    8'h10
`define STC_IDX_C1_CTRL   8'h11
`define STC_IDX_C2_HIGH   8'h12
`define STC_IDX_C2_LOW    8'h13
`define STC_IDX_C2_CTRL   8'h14
`define STC_IDX_IRQ_CTRL  8'h15

// ------------------------------------------------------------
// control field positions and masks
// ------------------------------------------------------------
`define STC_CTRL_EDGE     3
`define STC_CTRL_ENABLE   4
`define STC_CTRL_MODE_LO  6
`define STC_CTRL_MODE_HI  7
`define STC_CTRL_MASK     8'hd8
`define STC_CTRL_RESET    8'h08

// ------------------------------------------------------------
// interrupt control fields
// ------------------------------------------------------------
`define STC_IRQ_EN0       0
`define STC_IRQ_FLAG0     5
`define STC_IRQ_MASK      8'he7
`define STC_IRQ_RESET     8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define STC_INSTR_DIV     2'h3
`define STC_COUNT_MAX     16'hffff

`endif

/* hdl/stc_pkg.sv */
// types of the timer block
package stc_pkg;

  typedef enum logic [1:0] {
    STC_MODE_UNUSED,
    STC_MODE_EVENT,
    STC_MODE_TIMER,
    STC_MODE_PULSE
  } stc_mode_t;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } stc_sync_t;

  typedef struct packed {
    logic [1:0] div;
    logic       tick;
  } stc_tick_t;

  typedef struct packed {
    logic [2:0][15:0] count;
    logic [2:0][15:0] preload;
    logic [2:0][7:0]  low_buf;
    logic [2:0][7:0]  ctrl;
    logic [1:0]       pin_prev;
    logic [1:0]       measuring;
    logic [7:0]       irq_ctrl;
    logic             dp_sel;
    logic             dp_write;
    logic [7:0]       dp_idx;
    logic [31:0]      rdata;
    logic             ready;
    logic [2:0]       irq;
    logic             wake;
  } stc_state_t;

endpackage

/* hdl/stc_sync.sv */
// two-stage synchroniser for the two external count inputs
`timescale 1ns/100ps
module stc_sync
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // pins and synchronised levels
  input  wire logic [1:0] pin_in,
  output logic      [1:0] pin_sync
);

  stc_sync_t st;
  stc_sync_t next_st;

  always_comb
  begin
    next_st.meta   = pin_in;
    next_st.stable = st.meta;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_sync = st.stable;

endmodule // stc_sync

/* hdl/stc_tick.sv */
// instruction clock tick, one pulse every fourth system clock
`timescale 1ns/100ps
`include "stc_map.svh"
module stc_tick
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // instruction clock pulse
  output logic      tick
);

  stc_tick_t st;
  stc_tick_t next_st;

  always_comb
  begin
    next_st.div  = st.div + 2'h1;
    next_st.tick = (st.div == `STC_INSTR_DIV);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule // stc_tick

/* hdl/stc_timer.sv */
// three 16-bit timer counters behind an AHB-Lite slave, counters 0 and 1 also event counters
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "stc_map.svh"
module stc_timer
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // external count inputs
  input  wire logic        counter0_ext_input,
  input  wire logic        counter1_ext_input,
  // requests to the processor
  output logic      [2:0]  counter_irq_request,
  output logic             wake_up
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  stc_state_t st;
  stc_state_t next_st;
  logic [1:0] pin_sync;
  logic       tick;

  // ------------------------------------------------------------
  // input synchroniser and instruction clock
  // ------------------------------------------------------------
  stc_sync u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .pin_in   ({counter1_ext_input, counter0_ext_input}),
    .pin_sync (pin_sync)
  );

  stc_tick u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // index helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] high_idx(input int ch);
    logic [7:0] r;
    r = `STC_IDX_C0_HIGH;
    case (ch)
      1:       r = `STC_IDX_C1_HIGH;
      2:       r = `STC_IDX_C2_HIGH;
      default: r = `STC_IDX_C0_HIGH;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] low_idx(input int ch);
    logic [7:0] r;
    r = `STC_IDX_C0_LOW;
    case (ch)
      1:       r = `STC_IDX_C1_LOW;
      2:       r = `STC_IDX_C2_LOW;
      default: r = `STC_IDX_C0_LOW;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] ctrl_idx(input int ch);
    logic [7:0] r;
    r = `STC_IDX_C0_CTRL;
    case (ch)
      1:       r = `STC_IDX_C1_CTRL;
      2:       r = `STC_IDX_C2_CTRL;
      default: r = `STC_IDX_C0_CTRL;
    endcase
    return r;
  endfunction

  // ------------------------------------------------------------
  // address phase decode
  // ------------------------------------------------------------
  logic       addr_take;
  logic [7:0] addr_idx;
  logic       addr_hit;

  always_comb
  begin
    addr_take = hsel && htrans[1] && hready;
    addr_idx  = haddr[9:2];
    addr_hit  = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [2:0] blocked;
    logic [2:0] inc;
    logic [2:0] ovf;
    logic       level;
    logic       rise;
    logic       fall;
    logic       start_edge;
    logic       end_edge;
    logic       en;
    stc_mode_t  mode;

    next_st      = st;
    next_st.wake = 1'b0;
    blocked      = 3'h0;
    inc          = 3'h0;
    ovf          = 3'h0;
    level        = 1'b0;
    rise         = 1'b0;
    fall         = 1'b0;
    start_edge   = 1'b0;
    end_edge     = 1'b0;
    en           = 1'b0;
    mode         = STC_MODE_UNUSED;

    // data phase write, applied before counting so reads see it
    if (st.dp_sel && st.dp_write)
    begin
      for (int ch = 0; ch < 3; ch++)
      begin
        if (st.dp_idx == low_idx(ch))
          next_st.low_buf[ch] = hwdata[7:0];
        if (st.dp_idx == high_idx(ch))
        begin
          next_st.preload[ch] = {hwdata[7:0], st.low_buf[ch]};
          if (!st.ctrl[ch][`STC_CTRL_ENABLE])
            next_st.count[ch] = {hwdata[7:0], st.low_buf[ch]};
        end
        if (st.dp_idx == ctrl_idx(ch))
          next_st.ctrl[ch] = hwdata[7:0] & `STC_CTRL_MASK;
      end
      if (st.dp_idx == `STC_IDX_IRQ_CTRL)
        next_st.irq_ctrl = hwdata[7:0] & `STC_IRQ_MASK;
    end

    // count clock held off while the high byte is read
    if (addr_take && addr_hit && !hwrite)
    begin
      for (int ch = 0; ch < 3; ch++)
      begin
        if (addr_idx == high_idx(ch))
          blocked[ch] = 1'b1;
      end
    end

    // counting
    for (int ch = 0; ch < 3; ch++)
    begin
      en   = next_st.ctrl[ch][`STC_CTRL_ENABLE];
      mode = stc_mode_t'(next_st.ctrl[ch][`STC_CTRL_MODE_HI:`STC_CTRL_MODE_LO]);
      if (ch < 2)
      begin
        level      = pin_sync[ch];
        rise       = level && !st.pin_prev[ch];
        fall       = !level && st.pin_prev[ch];
        start_edge = next_st.ctrl[ch][`STC_CTRL_EDGE] ? fall : rise;
        end_edge   = next_st.ctrl[ch][`STC_CTRL_EDGE] ? rise : fall;
        unique case (mode)
          STC_MODE_EVENT:
            inc[ch] = en && start_edge;
          STC_MODE_TIMER:
            inc[ch] = en && tick;
          STC_MODE_PULSE:
          begin
            // measurement opens on the edge opposite the active one, which closes it
            if (!en)
              next_st.measuring[ch] = 1'b0;
            else if (!st.measuring[ch] && end_edge)
              next_st.measuring[ch] = 1'b1;
            else if (st.measuring[ch] && start_edge)
            begin
              next_st.measuring[ch]                  = 1'b0;
              next_st.ctrl[ch][`STC_CTRL_ENABLE]     = 1'b0;
            end
            inc[ch] = en && st.measuring[ch] && !start_edge && tick;
          end
          STC_MODE_UNUSED:
            inc[ch] = 1'b0;
        endcase
        if (mode != STC_MODE_PULSE)
          next_st.measuring[ch] = 1'b0;
      end
      else
      begin
        inc[ch] = en && tick && (mode == STC_MODE_TIMER);
      end

      if (blocked[ch])
        inc[ch] = 1'b0;

      if (inc[ch])
      begin
        if (next_st.count[ch] == `STC_COUNT_MAX)
        begin
          ovf[ch]           = 1'b1;
          next_st.count[ch] = next_st.preload[ch];
        end
        else
        begin
          next_st.count[ch] = next_st.count[ch] + 16'h0001;
        end
      end
    end

    next_st.pin_prev = pin_sync;

    // flags set by overflow win over a clear in the same cycle
    for (int ch = 0; ch < 3; ch++)
    begin
      if (ovf[ch])
        next_st.irq_ctrl[`STC_IRQ_FLAG0 + ch] = 1'b1;
      next_st.irq[ch] = next_st.irq_ctrl[`STC_IRQ_FLAG0 + ch]
                        && next_st.irq_ctrl[`STC_IRQ_EN0 + ch];
    end
    next_st.wake = |ovf;

    // address phase capture and read data
    next_st.ready = 1'b1;
    if (addr_take)
    begin
      next_st.dp_sel   = addr_hit;
      next_st.dp_write = hwrite;
      next_st.dp_idx   = addr_idx;
      next_st.rdata    = 32'h00000000;
      if (addr_hit && !hwrite)
      begin
        for (int ch = 0; ch < 3; ch++)
        begin
          if (addr_idx == high_idx(ch))
          begin
            next_st.rdata[7:0]  = next_st.count[ch][15:8];
            next_st.low_buf[ch] = next_st.count[ch][7:0];
          end
          if (addr_idx == low_idx(ch))
            next_st.rdata[7:0] = next_st.low_buf[ch];
          if (addr_idx == ctrl_idx(ch))
            next_st.rdata[7:0] = next_st.ctrl[ch] & `STC_CTRL_MASK;
        end
        if (addr_idx == `STC_IDX_IRQ_CTRL)
          next_st.rdata[7:0] = next_st.irq_ctrl;
      end
    end
    else if (hready)
    begin
      next_st.dp_sel   = 1'b0;
      next_st.dp_write = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st          <= '0;
      st.ctrl[0]  <= `STC_CTRL_RESET;
      st.ctrl[1]  <= `STC_CTRL_RESET;
      st.ctrl[2]  <= `STC_CTRL_RESET;
      st.irq_ctrl <= `STC_IRQ_RESET;
      st.ready    <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hrdata              = st.rdata;
  assign hreadyout           = st.ready;
  assign hresp               = 1'b0;
  assign counter_irq_request = st.irq;
  assign wake_up             = st.wake;

endmodule // stc_timer

/* testbench/stc_pin_src.sv */
// external event and pulse source on the two count pins
`timescale 1ns/100ps
module stc_pin_src (
  // clock
  input  wire logic       hclk,
  // count pins
  output logic      [1:0] pin
);
  initial pin = 2'h0;
  // each level held two clocks or more
  task automatic level(input int ch, input logic v, input int w);
    @(posedge hclk);
    pin[ch] <= v;
    repeat (w < 2 ? 2 : w) @(posedge hclk);
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge hclk);
      pin <= 2'h3;
      repeat (3) @(posedge hclk);
      pin <= 2'h0;
      repeat (3) @(posedge hclk);
    end
  endtask
endmodule // stc_pin_src

/* testbench/stc_timer_asserts.sv */
// port checks for the timer block
`timescale 1ns/100ps
`include "stc_map.svh"
module stc_timer_asserts
  import stc_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and requests
  input wire logic        counter0_ext_input,
  input wire logic        counter1_ext_input,
  input wire logic [2:0]  counter_irq_request,
  input wire logic        wake_up
);
  wire       take = hsel & htrans[1] & hready;
  wire [7:0] idx  = haddr[9:2];
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // bus steps
  // ------------------------------------------------------------
  sequence s_rd(logic [7:0] i);
    take && !hwrite && haddr == {22'h0, i, 2'h0};
  endsequence
  sequence s_irq_off;
    take && hwrite && haddr == {22'h0, `STC_IDX_IRQ_CTRL, 2'h0} ##1 hwdata[2:0] == 3'h0;
  endsequence
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_no_wait: assert property (hreadyout) else $error("wait state seen");
  chk_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read data set");
  chk_rdata_hold: assert property (!take |=> $stable(hrdata)) else $error("read data moved");
  chk_ctrl_unused: assert property (s_rd(`STC_IDX_C0_CTRL) or s_rd(`STC_IDX_C1_CTRL)
    |=> (hrdata[7:0] & 8'h27) == 8'h0) else $error("control unused bits set");
  chk_irq_unused: assert property (s_rd(`STC_IDX_IRQ_CTRL) |=> hrdata[4:3] == 2'h0)
    else $error("irq control unused bits set");
  chk_unmapped_zero: assert property (take && !hwrite && (idx < 8'h0c || idx > 8'h15)
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_irq_masked: assert property (s_irq_off |-> ##3 counter_irq_request == 3'h0)
    else $error("request with enable cleared");
  chk_wake_pulse: assert property ($rose(wake_up) |=> !wake_up [*2])
    else $error("wake pulse too long");
endmodule // stc_timer_asserts

bind stc_timer stc_timer_asserts chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .counter0_ext_input(counter0_ext_input), .counter1_ext_input(counter1_ext_input),
  .counter_irq_request(counter_irq_request), .wake_up(wake_up));

/* testbench/tb_stc_timer.sv */
// self-checking bench for the timer block
`timescale 1ns/100ps
`include "stc_map.svh"
module tb_stc_timer;
  import stc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  pin;
  logic [2:0]  irq;
  logic        wake_up;
  logic [7:0]  rd;
  int          n_errors = 0;
  int          comparisons = 0;

  always #2.5 hclk = ~hclk;

  stc_timer uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .counter0_ext_input(pin[0]),
    .counter1_ext_input(pin[1]), .counter_irq_request(irq), .wake_up(wake_up));
  stc_pin_src src (.hclk(hclk), .pin(pin));

  // ------------------------------------------------------------
  // bus and compare tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_hi(input bit wk, input int n);
    repeat (n)
    begin
      @(posedge hclk);
      if ((wk ? wake_up : hreadyout) === 1'b1)
        return;
    end
    $display("ERROR timeout expected 1 seen 0");
    n_errors++;
    end_of_test();
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    haddr  <= {22'h0, i, 2'h0};
    wait_hi(1'b0, 16);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_hi(1'b0, 16);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input string what, input logic [7:0] i, input logic [7:0] exp);
    xfer(1'b0, i, 8'h0);
    chk(what, {8'h0, exp}, {8'h0, rd});
  endtask
  function automatic logic [7:0] hi_i(input int c);
    return 8'(`STC_IDX_C0_HIGH + 3 * c);
  endfunction
  task automatic ld(input int c, input logic [15:0] p);
    wr(hi_i(c) + 8'h1, p[7:0]);
    wr(hi_i(c), p[15:8]);
  endtask
  task automatic rdcnt(input int c, output logic [15:0] v);
    xfer(1'b0, hi_i(c), 8'h0);
    v[15:8] = rd;
    xfer(1'b0, hi_i(c) + 8'h1, 8'h0);
    v[7:0] = rd;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    logic [15:0] v;
    logic [15:0] w;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int c = 0; c < 3; c++)
    begin
      rdchk("ctrl reset", hi_i(c) + 8'h2, `STC_CTRL_RESET);
      wr(hi_i(c) + 8'h2, 8'hff);
      rdchk("ctrl mask", hi_i(c) + 8'h2, `STC_CTRL_MASK);
      wr(hi_i(c) + 8'h2, `STC_CTRL_RESET);
    end
    rdchk("irq reset", `STC_IDX_IRQ_CTRL, `STC_IRQ_RESET);
    wr(8'h16, 8'h5a);
    rdchk("unmapped", 8'h16, 8'h00);
    $display("test registers done");
    wr(8'h0d, 8'h34);
    rdchk("low buffer", 8'h0d, 8'h34);
    rdcnt(0, v);
    chk("count after low write", 16'h0000, v);
    ld(0, 16'h1234);
    rdcnt(0, v);
    chk("stopped preload", 16'h1234, v);
    $display("test preload done");
    ld(0, 16'hfff0);
    ld(2, 16'hfff0);
    wr(`STC_IDX_IRQ_CTRL, 8'h05);
    wr(`STC_IDX_C0_CTRL, 8'h90);
    wr(`STC_IDX_C2_CTRL, 8'h90);
    wait_hi(1'b1, 200);
    ld(0, 16'h8000);
    rdchk("running count", 8'h0c, 8'hff);
    wait_hi(1'b1, 200);
    rdchk("reload count", 8'h0c, 8'h80);
    rdchk("enable kept", `STC_IDX_C0_CTRL, 8'h90);
    rdchk("flags", `STC_IDX_IRQ_CTRL, 8'ha5);
    chk("request", 16'h5, {13'h0, irq});
    wr(`STC_IDX_C0_CTRL, 8'h08);
    wr(`STC_IDX_C2_CTRL, 8'h08);
    wr(`STC_IDX_IRQ_CTRL, 8'ha0);
    repeat (4) @(posedge hclk);
    chk("masked request", 16'h0, {13'h0, irq});
    wr(`STC_IDX_IRQ_CTRL, 8'h00);
    $display("test timer done");
    ld(0, 16'h0000);
    ld(1, 16'h0000);
    wr(`STC_IDX_C0_CTRL, 8'h10);
    wr(`STC_IDX_C1_CTRL, 8'h50);
    src.pulses(3);
    src.level(1, 1'b1, 8);
    wr(`STC_IDX_C1_CTRL, 8'h58);
    src.level(1, 1'b0, 8);
    src.level(1, 1'b1, 8);
    rdcnt(1, v);
    chk("event count", 16'h0005, v);
    rdcnt(0, v);
    chk("unused mode", 16'h0000, v);
    $display("test event done");
    wr(`STC_IDX_C0_CTRL, 8'h08);
    src.level(0, 1'b1, 8);
    wr(`STC_IDX_C0_CTRL, 8'hd8);
    repeat (20) @(posedge hclk);
    rdcnt(0, v);
    chk("level no start", 16'h0000, v);
    src.level(0, 1'b0, 8);
    src.level(0, 1'b1, 40);
    src.level(0, 1'b0, 12);
    rdcnt(0, v);
    chk("pulse width", 16'h1, {15'h0, v >= 16'd9 && v <= 16'd11});
    rdchk("enable cleared", `STC_IDX_C0_CTRL, 8'hc8);
    src.level(0, 1'b1, 20);
    src.level(0, 1'b0, 12);
    rdcnt(0, w);
    chk("result kept", v, w);
    wr(`STC_IDX_C0_CTRL, 8'hd8);
    src.level(0, 1'b1, 20);
    src.level(0, 1'b0, 12);
    rdcnt(0, w);
    chk("rearmed", 16'h1, {15'h0, w > v});
    $display("test pulse done");
    end_of_test();
  end
endmodule // tb_stc_timer
